// ==== design/prhg_consts.vh ====
`ifndef PRHG_CONSTS_VH
`define PRHG_CONSTS_VH
// octet width of the output
`define PRHG_OCTET_W 8
// total-failure test: longest run of equal raw bits tolerated, not counting the first bit of the run
`define PRHG_TF_RUN_MAX 16'h0040
// total-failure test: longest silence of the raw strobe, in clocks
`define PRHG_TF_IDLE_MAX 16'h0100
// online test window length in raw bits
`define PRHG_OT_WIN 16'h0400
// tolerated ones count bounds within one window
`define PRHG_OT_ONES_MIN 16'h01C0
`define PRHG_OT_ONES_MAX 16'h0240
// periodic mode: idle raw bits between two test windows
`define PRHG_OT_GAP 16'h1000
// mode select encoding
`define PRHG_MODE_PERIODIC 1'b0
`define PRHG_MODE_CONTINUOUS 1'b1
`endif

// ==== design/prhg_sync.v ====
`timescale 1ns/1ns
// two-stage synchroniser for raw pin inputs
module prhg_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire         ce,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= {W{1'b0}};
      stage2_reg <= {W{1'b0}};
    end else if (ce) begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end
  assign dout = stage2_reg;
endmodule

// ==== design/prhg_online_test.v ====
`timescale 1ns/1ns
`include "prhg_consts.vh"
// monobit window test: counts ones over a window and checks the bounds
module prhg_online_test #(
  parameter WIN      = `PRHG_OT_WIN,
  parameter ONES_MIN = `PRHG_OT_ONES_MIN,
  parameter ONES_MAX = `PRHG_OT_ONES_MAX
) (
  input  wire clk,
  input  wire nrst,
  input  wire ce,
  input  wire restart,
  input  wire bitValid,
  input  wire rawBit,
  output reg  done,
  output reg  pass
);
  reg [15:0] bitCount_reg;
  reg [15:0] ones_reg;
  wire [15:0] onesNow = ones_reg + {15'h0000, rawBit};
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitCount_reg <= 16'h0000;
      ones_reg     <= 16'h0000;
      done         <= 1'b0;
      pass         <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (restart) begin
        bitCount_reg <= 16'h0000;
        ones_reg     <= 16'h0000;
      end else if (bitValid) begin
        if (bitCount_reg == WIN[15:0] - 16'h0001) begin
          bitCount_reg <= 16'h0000;
          ones_reg     <= 16'h0000;
          done         <= 1'b1;
          pass         <= (onesNow >= ONES_MIN[15:0]) && (onesNow <= ONES_MAX[15:0]);
        end else begin
          bitCount_reg <= bitCount_reg + 16'h0001;
          ones_reg     <= onesNow;
        end
      end
    end
  end
endmodule

// ==== design/prhg_gate.v ====
`timescale 1ns/1ns
`include "prhg_consts.vh"
module prhg_gate #(
  parameter TF_RUN_MAX  = `PRHG_TF_RUN_MAX,
  parameter TF_IDLE_MAX = `PRHG_TF_IDLE_MAX,
  parameter OT_WIN      = `PRHG_OT_WIN,
  parameter OT_ONES_MIN = `PRHG_OT_ONES_MIN,
  parameter OT_ONES_MAX = `PRHG_OT_ONES_MAX,
  parameter OT_GAP      = `PRHG_OT_GAP
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire       ce,
  input  wire       rngEnable,
  input  wire       testMode,
  input  wire       selfTestStart,
  input  wire       rawBitPin,
  input  wire       rawStrobePin,
  input  wire       octetRead,
  output reg  [7:0] octetData,
  output wire       octetValid,
  output reg        selfTestBusy,
  output reg        selfTestPass,
  output reg        selfTestDone,
  output reg        totalFailure,
  output reg        onlineDefect,
  output reg        healthReady
);
  localparam [3:0] ST_OFF     = 4'b0001;
  localparam [3:0] ST_STARTUP = 4'b0010;
  localparam [3:0] ST_RUN     = 4'b0100;
  localparam [3:0] ST_FAIL    = 4'b1000;

  wire [1:0] pinSync;
  wire       rawBit;
  wire       strobeLvl;
  reg        strobePrev_reg;
  wire       bitValid;

  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [15:0] runLen_reg;
  reg        lastBit_reg;
  reg [7:0]  shift_reg;
  reg [2:0]  bitCnt_reg;
  reg        fresh_reg;
  reg        testing_reg;
  reg [15:0] gap_reg;
  reg [15:0] idle_reg;
  reg        modeCont_reg;
  wire       otDone;
  wire       otPass;
  wire       tfHit;
  wire       tfRun;
  wire       tfIdle;
  wire       otRestart;
  wire       otBitValid;
  wire       healthy;

  // raw source comes from the analog domain, so resynchronise it first
  prhg_sync #(
    .W (2)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .din  ({rawStrobePin, rawBitPin}),
    .dout (pinSync)
  );
  assign rawBit    = pinSync[0];
  assign strobeLvl = pinSync[1];
  assign bitValid  = strobeLvl & ~strobePrev_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobePrev_reg <= 1'b0;
    end else if (ce) begin
      strobePrev_reg <= strobeLvl;
    end
  end

  // a stuck source shows as an over-long run of equal bits
  assign tfRun  = bitValid && (rawBit == lastBit_reg) && (runLen_reg >= TF_RUN_MAX[15:0]);
  // a dead source stops strobing, and the run test alone would never fire then
  assign tfIdle = (state_reg != ST_OFF) && (idle_reg >= TF_IDLE_MAX[15:0]);
  assign tfHit  = tfRun || tfIdle;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      runLen_reg  <= 16'h0000;
      lastBit_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_OFF) begin
        runLen_reg <= 16'h0000;
      end else if (bitValid) begin
        lastBit_reg <= rawBit;
        if (rawBit == lastBit_reg) begin
          if (runLen_reg != 16'hFFFF) begin
            runLen_reg <= runLen_reg + 16'h0001;
          end
        end else begin
          runLen_reg <= 16'h0000;
        end
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_reg <= 16'h0000;
    end else if (ce) begin
      if (state_reg == ST_OFF || bitValid) begin
        idle_reg <= 16'h0000;
      end else if (idle_reg != 16'hFFFF) begin
        idle_reg <= idle_reg + 16'h0001;
      end
    end
  end

  // online test is restarted on entry to start-up and by a self-test request
  assign otRestart = (state_reg == ST_OFF) || (selfTestStart && !selfTestBusy);

  assign otBitValid = bitValid && testing_reg;

  prhg_online_test #(
    .WIN      (OT_WIN),
    .ONES_MIN (OT_ONES_MIN),
    .ONES_MAX (OT_ONES_MAX)
  ) u_ot (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .restart  (otRestart),
    .bitValid (otBitValid),
    .rawBit   (rawBit),
    .done     (otDone),
    .pass     (otPass)
  );

  // the schedule is fixed while the generator runs, so a mode change cannot cut a
  // window short; software changes the mode with the generator off
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modeCont_reg <= `PRHG_MODE_PERIODIC;
    end else if (ce) begin
      if (state_reg == ST_OFF) begin
        modeCont_reg <= testMode;
      end
    end
  end

  // scheduling: continuous keeps testing, periodic idles for a gap between windows
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      testing_reg <= 1'b1;
      gap_reg     <= 16'h0000;
    end else if (ce) begin
      if (otRestart || state_reg == ST_STARTUP) begin
        testing_reg <= 1'b1;
        gap_reg     <= 16'h0000;
      end else if (modeCont_reg == `PRHG_MODE_CONTINUOUS) begin
        testing_reg <= 1'b1;
      end else if (otDone) begin
        testing_reg <= 1'b0;
        gap_reg     <= 16'h0000;
      end else if (!testing_reg && bitValid) begin
        if (gap_reg >= OT_GAP[15:0] - 16'h0001) begin
          testing_reg <= 1'b1;
        end else begin
          gap_reg <= gap_reg + 16'h0001;
        end
      end
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (rngEnable) begin
          state_next = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (!rngEnable) begin
          state_next = ST_OFF;
        end else if (tfHit || (otDone && !otPass)) begin
          state_next = ST_FAIL;
        end else if (otDone && otPass) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!rngEnable) begin
          state_next = ST_OFF;
        end else if (tfHit || (otDone && !otPass)) begin
          state_next = ST_FAIL;
        end
      end
      ST_FAIL: begin
        // failure is sticky until the generator is switched off
        if (!rngEnable) begin
          state_next = ST_OFF;
        end
      end
      default: begin
        state_next = ST_FAIL;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= ST_OFF;
      healthReady <= 1'b0;
    end else if (ce) begin
      state_reg   <= state_next;
      healthReady <= (state_next == ST_RUN);
    end
  end

  // failure flags are sticky; only switching the generator off clears them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      totalFailure <= 1'b0;
      onlineDefect <= 1'b0;
    end else if (ce) begin
      if (state_next == ST_OFF) begin
        totalFailure <= 1'b0;
        onlineDefect <= 1'b0;
      end else begin
        if (tfHit) begin
          totalFailure <= 1'b1;
        end
        if (otDone && !otPass) begin
          onlineDefect <= 1'b1;
        end
      end
    end
  end

  // octet assembly; any health loss discards the partial and the held octet
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg  <= 8'h00;
      bitCnt_reg <= 3'h0;
      fresh_reg  <= 1'b0;
      octetData  <= 8'h00;
    end else if (ce) begin
      if (state_next != ST_RUN || state_reg != ST_RUN) begin
        bitCnt_reg <= 3'h0;
        fresh_reg  <= 1'b0;
      end else begin
        if (octetRead && fresh_reg) begin
          fresh_reg <= 1'b0;
        end
        if (bitValid) begin
          shift_reg  <= {shift_reg[6:0], rawBit};
          bitCnt_reg <= bitCnt_reg + 3'h1;
          // an octet that completes while one is pending is dropped unless that one is read in the same cycle; data moves under valid only on a read
          if (bitCnt_reg == 3'h7 && (!fresh_reg || octetRead)) begin
            octetData <= {shift_reg[6:0], rawBit};
            fresh_reg <= 1'b1;
          end
        end
      end
    end
  end

  // the entropy bound is a property of the analog source, not checked here
  assign healthy    = healthReady && !totalFailure && !onlineDefect;
  assign octetValid = fresh_reg && healthy;

  // self-test: one full online window, ended early by a total failure
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      selfTestBusy <= 1'b0;
      selfTestPass <= 1'b0;
      selfTestDone <= 1'b0;
    end else if (ce) begin
      if (selfTestStart && !selfTestBusy) begin
        selfTestBusy <= 1'b1;
        selfTestDone <= 1'b0;
      end else if (selfTestBusy) begin
        // a dead source never finishes a window, so a total failure ends the test
        if (tfHit) begin
          selfTestBusy <= 1'b0;
          selfTestDone <= 1'b1;
          selfTestPass <= 1'b0;
        end else if (otDone) begin
          selfTestBusy <= 1'b0;
          selfTestDone <= 1'b1;
          selfTestPass <= otPass;
        end
      end
    end
  end
endmodule

// ==== testbench/prhg_source.sv ====
`timescale 1ns/1ns
// raw entropy source: one strobe rise every 4 clocks while running
module prhg_source (
  input  wire logic clk,
  input  wire logic on,
  input  wire logic stuck,
  output logic      rawBit    = 1'b0,
  output logic      rawStrobe = 1'b0
);
  logic [1:0] phase = 2'h0;
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    // strobe stands still while the generator is off
    rawStrobe <= on && phase[1];
    // bit changes a clock before the rise so it is steady through synchronisation
    if (phase == 2'h1) rawBit <= stuck ? 1'b1 : 1'($urandom);
  end
endmodule

// ==== testbench/prhg_gate_assertions.sv ====
`timescale 1ns/1ns
module prhg_gate_checker #(
  parameter TF_RUN_MAX = 64,
  parameter OT_GAP     = 4096
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic       rngEnable,
  input wire logic       testMode,
  input wire logic       selfTestStart,
  input wire logic       rawBitPin,
  input wire logic       rawStrobePin,
  input wire logic       octetRead,
  input wire logic [7:0] octetData,
  input wire logic       octetValid,
  input wire logic       selfTestBusy,
  input wire logic       selfTestPass,
  input wire logic       selfTestDone,
  input wire logic       totalFailure,
  input wire logic       onlineDefect,
  input wire logic       healthReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence sRead; octetValid && octetRead && ce; endsequence
  sequence sHold; octetValid && !octetRead && ce && rngEnable; endsequence
  AST_FAIL_BLOCKS: assert property (totalFailure |-> !octetValid)
    else $error("octet valid after total failure");
  AST_DEFECT_BLOCKS: assert property (onlineDefect |-> !octetValid)
    else $error("octet valid after online defect");
  AST_VALID_NEEDS_RUN: assert property (octetValid |-> healthReady)
    else $error("octet valid outside run");
  AST_RUN_IS_HEALTHY: assert property (healthReady |-> !totalFailure && !onlineDefect)
    else $error("run state with a failure flag");
  AST_READ_CLEARS: assert property (sRead |=> !octetValid)
    else $error("valid kept after read");
  AST_DATA_HELD: assert property (sHold |=> $stable(octetData) || !octetValid)
    else $error("octet changed while held");
  AST_FAIL_STICKY: assert property (totalFailure && rngEnable |=> totalFailure)
    else $error("total failure flag dropped");
  AST_OFF_CLEARS: assert property (!rngEnable && ce |=> !healthReady && !totalFailure)
    else $error("state kept while generator off");
  AST_NO_EARLY: assert property ($rose(rngEnable) |-> !octetValid [*8])
    else $error("octet before start-up test");
endmodule

bind prhg_gate prhg_gate_checker #(.TF_RUN_MAX(TF_RUN_MAX), .OT_GAP(OT_GAP)) chk (.*);

// ==== testbench/physical_rng_health_gate_test.sv ====
`timescale 1ns/1ns
module physical_rng_health_gate_test;
  logic       clk = 1'b0, nrst = 1'b0, rngEnable = 1'b0, testMode = 1'b0;
  logic       selfTestStart = 1'b0, octetRead = 1'b0, on = 1'b0, stuck = 1'b0;
  logic       rawBitPin, rawStrobePin, octetValid, selfTestBusy, selfTestPass;
  logic       selfTestDone, totalFailure, onlineDefect, healthReady;
  logic [7:0] octetData;
  logic       ce = 1'b1;
  logic [7:0] hist = 8'h00, snap;
  int         err_count = 0, tests_run = 0;

  initial forever #5 clk = ~clk;
  prhg_source src (.clk(clk), .on(on), .stuck(stuck), .rawBit(rawBitPin),
                   .rawStrobe(rawStrobePin));
  // short gap keeps periodic testing inside the run length
  prhg_gate #(.OT_GAP(16)) uut (
    .clk(clk), .nrst(nrst), .ce(ce), .rngEnable(rngEnable), .testMode(testMode),
    .selfTestStart(selfTestStart), .rawBitPin(rawBitPin), .rawStrobePin(rawStrobePin),
    .octetRead(octetRead), .octetData(octetData), .octetValid(octetValid),
    .selfTestBusy(selfTestBusy), .selfTestPass(selfTestPass), .selfTestDone(selfTestDone),
    .totalFailure(totalFailure), .onlineDefect(onlineDefect), .healthReady(healthReady)
  );
  // expected octet: the last eight raw bits seen on the pins, oldest in bit 7
  always @(posedge rawStrobePin) hist <= {hist[6:0], rawBitPin};

  function logic expPass(input logic s);
    return !s;
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function logic flag(input int w);
    return w == 0 ? healthReady : w == 1 ? totalFailure : w == 2 ? selfTestDone : octetValid;
  endfunction
  task waitFor(input int w, input int limit);
    int n;
    n = 0;
    while (flag(w) !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > limit) begin
        check(8'h00, 8'h01);
        summarize();
      end
    end
  endtask
  task genOff;
    @(posedge clk);
    rngEnable <= 1'b0;
    on <= 1'b0;
    stuck <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({healthReady, totalFailure, onlineDefect, octetValid}, 8'h00);
  endtask

  initial begin
    void'($urandom(70));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 check({healthReady, octetValid, selfTestBusy, selfTestDone, totalFailure}, 8'h00);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      testMode <= m[0];
      rngEnable <= 1'b1;
      on <= 1'b1;
      waitFor(0, 8000);
      for (int k = 0; k < 6; k++) begin
        waitFor(3, 200);
        check(octetData, hist);
        check(healthReady, 1'b1);
        repeat (1 + $urandom_range(3)) @(posedge clk);
        octetRead <= 1'b1;
        @(posedge clk);
        octetRead <= 1'b0;
        #1 check(octetValid, 1'b0);
      end
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      #1 snap = octetData;
      repeat (40) @(posedge clk);
      #1 check(octetData, snap);
      check(healthReady, 1'b1);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      stuck <= 1'b1;
      waitFor(1, 600);
      check({healthReady, octetValid}, 8'h00);
      genOff();
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      stuck <= s[0];
      rngEnable <= 1'b1;
      on <= 1'b1;
      selfTestStart <= 1'b1;
      @(posedge clk);
      selfTestStart <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check(selfTestBusy, 1'b1);
      waitFor(2, 8000);
      check({selfTestBusy, selfTestPass}, {1'b0, expPass(s[0])});
      check(totalFailure, s[0]);
      genOff();
    end
    // a silent source must count as a total failure
    @(posedge clk);
    rngEnable <= 1'b1;
    waitFor(1, 600);
    check({healthReady, octetValid}, 8'h00);
    genOff();
    summarize();
  end
endmodule
